// ===== gochr_pkg.sv
/*
 * Constants and types for the gain and offset channel register bank.
 * Assumes a classic Wishbone slave with 32-bit data; byte address is four times
 * the register index.
 */
// Contract
// - Green offset code is 8 bits, resets to zero, centred at mid-code.
// - Blue offset code is 8 bits, resets to zero, centred at mid-code.
// - Broadcast offset write loads red, green and blue offset codes together.
// - Red low-gain bit, reset zero, is bit 0 of red gain code.
// - Green low-gain bit, reset zero, is bit 0 of green gain code.
// - Blue low-gain bit, reset zero, is bit 0 of blue gain code.
// - Broadcast low-gain write copies the bit into all three channels.
// - Red high-gain register holds gain bits 8:1, resets to 0x0D.
// - Green high-gain register holds gain bits 8:1, resets to 0x0D.
// - Blue high-gain register holds gain bits 8:1, resets to 0x0D.
// - Broadcast high-gain write loads all three high-gain registers together.
// - Single clear: colour mode, or two-channel with blue amplifier off.
// - Single set, select 00: red only, green and blue amplifiers off.
// - Single set, select 01: green only, red and blue amplifiers off.
// - Single set, select 10: blue only, red and green amplifiers off.
// - Red offset code is 8 bits, resets to zero, centred at mid-code.
package gochr_pkg;

    // ****************************************************************
    // Register indices
    // ****************************************************************
    localparam logic [5:0] IDX_RED_OFFSET = 6'h20;
    localparam logic [5:0] IDX_GREEN_OFFSET = 6'h21;
    localparam logic [5:0] IDX_BLUE_OFFSET = 6'h22;
    localparam logic [5:0] IDX_ALL_OFFSET = 6'h23;
    localparam logic [5:0] IDX_RED_GAIN_LOW = 6'h24;
    localparam logic [5:0] IDX_GREEN_GAIN_LOW = 6'h25;
    localparam logic [5:0] IDX_BLUE_GAIN_LOW = 6'h26;
    localparam logic [5:0] IDX_ALL_GAIN_LOW = 6'h27;
    localparam logic [5:0] IDX_RED_GAIN_HIGH = 6'h28;
    localparam logic [5:0] IDX_GREEN_GAIN_HIGH = 6'h29;
    localparam logic [5:0] IDX_BLUE_GAIN_HIGH = 6'h2A;
    localparam logic [5:0] IDX_ALL_GAIN_HIGH = 6'h2B;
    localparam logic [5:0] IDX_MODE_CTRL = 6'h2C;
    localparam logic [5:0] IDX_MODE_STATUS = 6'h2D;

    // ****************************************************************
    // Reset values and field layout
    // ****************************************************************
    localparam logic [7:0] RST_OFFSET = 8'h00;
    localparam logic [7:0] RST_GAIN_HIGH = 8'h0D;
    localparam logic RST_GAIN_LOW = 1'b0;
    localparam logic [1:0] SEL_RED = 2'h0;
    localparam logic [1:0] SEL_GREEN = 2'h1;
    localparam logic [1:0] SEL_BLUE = 2'h2;
    localparam int AMP_RED = 0;
    localparam int AMP_GREEN = 1;
    localparam int AMP_BLUE = 2;
    localparam logic [2:0] AMP_ALL = 3'h7;
    localparam logic [2:0] AMP_NONE = 3'h0;
    localparam int STAT_INVALID = 3;

    typedef struct packed {
        logic [8:0] gain;
        logic [7:0] offset;
    } gochr_chan_type;

    typedef struct packed {
        logic single_channel_setting;
        logic two_channel_setting;
        logic [1:0] channel_select;
    } gochr_mode_ctrl_type;

    typedef enum logic [2:0] {
        MODE_COLOUR,
        MODE_TWO_CHANNEL,
        MODE_SINGLE_RED,
        MODE_SINGLE_GREEN,
        MODE_SINGLE_BLUE,
        MODE_INVALID
    } gochr_mode_type;

endpackage

// ===== gochr_regs.sv
/*
 * Gain and offset register bank for three colour channels, with channel mode
 * decode, reached as a classic Wishbone slave.
 * Assumes one clock, synchronous active-high reset and a master that holds its
 * request until ack.
 */
`timescale 1ns/1ps

module gochr_regs #(
    parameter int ADDR_W = 8
) (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ADDR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Channel settings
    output gochr_pkg::gochr_chan_type red_o,
    output gochr_pkg::gochr_chan_type green_o,
    output gochr_pkg::gochr_chan_type blue_o,
    // Mode decode
    output logic [2:0] amp_enable_o,
    output gochr_pkg::gochr_mode_type op_mode_o,
    output logic mode_invalid_o
);

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    logic ack_ff;
    logic [31:0] dat_ff;
    logic [31:0] nxt_dat;
    logic [5:0] idx;
    logic req_go;
    logic wr_go;
    logic [7:0] wdat;

    assign idx = adr_i[7:2];
    assign req_go = ce_i && cyc_i && stb_i && !ack_ff;
    assign wr_go = req_go && we_i && sel_i[0];
    assign wdat = dat_i[7:0];

    // Ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
        end else if (ce_i) begin
            ack_ff <= req_go;
        end
    end

    // ****************************************************************
    // Channel registers
    // ****************************************************************
    // Each field is its own register so that every one has a single writer
    logic [7:0] red_off_ff;
    logic [7:0] green_off_ff;
    logic [7:0] blue_off_ff;
    logic red_glo_ff;
    logic green_glo_ff;
    logic blue_glo_ff;
    logic [7:0] red_ghi_ff;
    logic [7:0] green_ghi_ff;
    logic [7:0] blue_ghi_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            red_off_ff <= gochr_pkg::RST_OFFSET;
        end else if (wr_go && (idx == gochr_pkg::IDX_RED_OFFSET ||
                               idx == gochr_pkg::IDX_ALL_OFFSET)) begin
            red_off_ff <= wdat;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            green_off_ff <= gochr_pkg::RST_OFFSET;
        end else if (wr_go && (idx == gochr_pkg::IDX_GREEN_OFFSET ||
                               idx == gochr_pkg::IDX_ALL_OFFSET)) begin
            green_off_ff <= wdat;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            blue_off_ff <= gochr_pkg::RST_OFFSET;
        end else if (wr_go && (idx == gochr_pkg::IDX_BLUE_OFFSET ||
                               idx == gochr_pkg::IDX_ALL_OFFSET)) begin
            blue_off_ff <= wdat;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            red_glo_ff <= gochr_pkg::RST_GAIN_LOW;
        end else if (wr_go && (idx == gochr_pkg::IDX_RED_GAIN_LOW ||
                               idx == gochr_pkg::IDX_ALL_GAIN_LOW)) begin
            red_glo_ff <= wdat[0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            green_glo_ff <= gochr_pkg::RST_GAIN_LOW;
        end else if (wr_go && (idx == gochr_pkg::IDX_GREEN_GAIN_LOW ||
                               idx == gochr_pkg::IDX_ALL_GAIN_LOW)) begin
            green_glo_ff <= wdat[0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            blue_glo_ff <= gochr_pkg::RST_GAIN_LOW;
        end else if (wr_go && (idx == gochr_pkg::IDX_BLUE_GAIN_LOW ||
                               idx == gochr_pkg::IDX_ALL_GAIN_LOW)) begin
            blue_glo_ff <= wdat[0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            red_ghi_ff <= gochr_pkg::RST_GAIN_HIGH;
        end else if (wr_go && (idx == gochr_pkg::IDX_RED_GAIN_HIGH ||
                               idx == gochr_pkg::IDX_ALL_GAIN_HIGH)) begin
            red_ghi_ff <= wdat;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            green_ghi_ff <= gochr_pkg::RST_GAIN_HIGH;
        end else if (wr_go && (idx == gochr_pkg::IDX_GREEN_GAIN_HIGH ||
                               idx == gochr_pkg::IDX_ALL_GAIN_HIGH)) begin
            green_ghi_ff <= wdat;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            blue_ghi_ff <= gochr_pkg::RST_GAIN_HIGH;
        end else if (wr_go && (idx == gochr_pkg::IDX_BLUE_GAIN_HIGH ||
                               idx == gochr_pkg::IDX_ALL_GAIN_HIGH)) begin
            blue_ghi_ff <= wdat;
        end
    end

    // ****************************************************************
    // Mode control and decode
    // ****************************************************************
    gochr_pkg::gochr_mode_ctrl_type mode_ff;
    gochr_pkg::gochr_mode_type op_mode_ff;
    gochr_pkg::gochr_mode_type nxt_op_mode;
    logic [2:0] amp_en_ff;
    logic [2:0] nxt_amp_en;
    logic invalid_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_ff <= '0;
        end else if (wr_go && idx == gochr_pkg::IDX_MODE_CTRL) begin
            mode_ff <= wdat[3:0];
        end
    end

    always_comb begin
        nxt_op_mode = gochr_pkg::MODE_INVALID;
        nxt_amp_en = gochr_pkg::AMP_NONE;
        if (!mode_ff.single_channel_setting) begin
            nxt_amp_en = gochr_pkg::AMP_ALL;
            if (mode_ff.two_channel_setting) begin
                nxt_op_mode = gochr_pkg::MODE_TWO_CHANNEL;
                nxt_amp_en[gochr_pkg::AMP_BLUE] = 1'b0;
            end else begin
                nxt_op_mode = gochr_pkg::MODE_COLOUR;
            end
        end else if (!mode_ff.two_channel_setting) begin
            case (mode_ff.channel_select)
                gochr_pkg::SEL_RED: begin
                    nxt_op_mode = gochr_pkg::MODE_SINGLE_RED;
                    nxt_amp_en[gochr_pkg::AMP_RED] = 1'b1;
                end
                gochr_pkg::SEL_GREEN: begin
                    nxt_op_mode = gochr_pkg::MODE_SINGLE_GREEN;
                    nxt_amp_en[gochr_pkg::AMP_GREEN] = 1'b1;
                end
                gochr_pkg::SEL_BLUE: begin
                    nxt_op_mode = gochr_pkg::MODE_SINGLE_BLUE;
                    nxt_amp_en[gochr_pkg::AMP_BLUE] = 1'b1;
                end
                default: begin
                    nxt_op_mode = gochr_pkg::MODE_INVALID;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            op_mode_ff <= gochr_pkg::MODE_COLOUR;
            amp_en_ff <= gochr_pkg::AMP_ALL;
            invalid_ff <= 1'b0;
        end else if (ce_i) begin
            op_mode_ff <= nxt_op_mode;
            amp_en_ff <= nxt_amp_en;
            // Invalid flag is registered together with the mode it describes
            invalid_ff <= (nxt_op_mode == gochr_pkg::MODE_INVALID);
        end
    end

    // ****************************************************************
    // Read back
    // ****************************************************************
    // read back of stored values
    always_comb begin
        nxt_dat = '0;
        case (idx)
            gochr_pkg::IDX_RED_OFFSET: nxt_dat[7:0] = red_off_ff;
            gochr_pkg::IDX_GREEN_OFFSET: nxt_dat[7:0] = green_off_ff;
            gochr_pkg::IDX_BLUE_OFFSET: nxt_dat[7:0] = blue_off_ff;
            gochr_pkg::IDX_RED_GAIN_LOW: nxt_dat[0] = red_glo_ff;
            gochr_pkg::IDX_GREEN_GAIN_LOW: nxt_dat[0] = green_glo_ff;
            gochr_pkg::IDX_BLUE_GAIN_LOW: nxt_dat[0] = blue_glo_ff;
            gochr_pkg::IDX_RED_GAIN_HIGH: nxt_dat[7:0] = red_ghi_ff;
            gochr_pkg::IDX_GREEN_GAIN_HIGH: nxt_dat[7:0] = green_ghi_ff;
            gochr_pkg::IDX_BLUE_GAIN_HIGH: nxt_dat[7:0] = blue_ghi_ff;
            gochr_pkg::IDX_MODE_CTRL: nxt_dat[3:0] = mode_ff;
            gochr_pkg::IDX_MODE_STATUS: begin
                nxt_dat[2:0] = amp_en_ff;
                nxt_dat[gochr_pkg::STAT_INVALID] = invalid_ff;
            end
            default: nxt_dat = '0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_ff <= '0;
        end else if (req_go) begin
            dat_ff <= we_i ? '0 : nxt_dat;
        end
    end

    assign dat_o = dat_ff;
    assign ack_o = ack_ff;
    assign red_o = {red_ghi_ff, red_glo_ff, red_off_ff};
    assign green_o = {green_ghi_ff, green_glo_ff, green_off_ff};
    assign blue_o = {blue_ghi_ff, blue_glo_ff, blue_off_ff};
    assign amp_enable_o = amp_en_ff;
    assign op_mode_o = op_mode_ff;
    assign mode_invalid_o = invalid_ff;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence wr_s(logic [5:0] i);
        wr_go && idx == i;
    endsequence

    sequence rd_s(logic [5:0] i);
        req_go && !we_i && idx == i;
    endsequence

    red_off_a: assert property (wr_s(gochr_pkg::IDX_RED_OFFSET) |=>
        red_o.offset == $past(wdat) && green_o.offset == $past(green_o.offset))
        else $error("red offset write not stored");
    green_off_a: assert property (wr_s(gochr_pkg::IDX_GREEN_OFFSET) |=>
        green_o.offset == $past(wdat) && blue_o.offset == $past(blue_o.offset))
        else $error("green offset write not stored");
    blue_off_a: assert property (wr_s(gochr_pkg::IDX_BLUE_OFFSET) |=>
        blue_o.offset == $past(wdat) && red_o.offset == $past(red_o.offset))
        else $error("blue offset write not stored");
    bcast_off_a: assert property (wr_s(gochr_pkg::IDX_ALL_OFFSET) |=>
        red_o.offset == $past(wdat) && green_o.offset == $past(wdat)
        && blue_o.offset == $past(wdat))
        else $error("broadcast offset missed a channel");
    bcast_low_a: assert property (wr_s(gochr_pkg::IDX_ALL_GAIN_LOW) |=>
        red_o.gain[0] == $past(wdat[0]) && green_o.gain[0] == $past(wdat[0])
        && blue_o.gain[0] == $past(wdat[0]))
        else $error("broadcast low gain missed a channel");
    red_low_a: assert property (wr_s(gochr_pkg::IDX_RED_GAIN_LOW) |=>
        red_o.gain == {$past(red_o.gain[8:1]), $past(wdat[0])})
        else $error("red low gain bit wrong");
    bcast_high_a: assert property (wr_s(gochr_pkg::IDX_ALL_GAIN_HIGH) |=>
        red_o.gain[8:1] == $past(wdat) && green_o.gain[8:1] == $past(wdat)
        && blue_o.gain[8:1] == $past(wdat))
        else $error("broadcast high gain missed a channel");
    gain_reset_a: assert property (disable iff (1'b0) rst_i |=>
        red_o.gain == {gochr_pkg::RST_GAIN_HIGH, gochr_pkg::RST_GAIN_LOW}
        && green_o.gain[8:1] == gochr_pkg::RST_GAIN_HIGH
        && blue_o.gain[8:1] == gochr_pkg::RST_GAIN_HIGH)
        else $error("gain reset value wrong");
    two_chan_a: assert property (ce_i && !mode_ff.single_channel_setting
        && mode_ff.two_channel_setting |=> amp_enable_o == 3'h3)
        else $error("two-channel mode left blue amplifier on");
    single_channel_setting_amp_a: assert property (ce_i && mode_ff.single_channel_setting
        && !mode_ff.two_channel_setting && mode_ff.channel_select == gochr_pkg::SEL_GREEN
        |=> amp_enable_o == 3'h2 && op_mode_o == gochr_pkg::MODE_SINGLE_GREEN)
        else $error("single green mode decode wrong");
    readback_a: assert property (rd_s(gochr_pkg::IDX_BLUE_GAIN_HIGH) |=>
        ack_o && dat_o == {24'h0, $past(blue_o.gain[8:1])})
        else $error("blue high gain not read back");
    green_rd_a: assert property (rd_s(gochr_pkg::IDX_GREEN_OFFSET) |=>
        ack_o && dat_o == {24'h0, $past(green_o.offset)})
        else $error("green offset not read back");
    red_low_rd_a: assert property (rd_s(gochr_pkg::IDX_RED_GAIN_LOW) |=>
        ack_o && dat_o == {31'h0, $past(red_o.gain[0])})
        else $error("red low gain not read back");
    green_low_a: assert property (wr_s(gochr_pkg::IDX_GREEN_GAIN_LOW) |=>
        green_o.gain == {$past(green_o.gain[8:1]), $past(wdat[0])})
        else $error("green low gain bit wrong");
    blue_low_a: assert property (wr_s(gochr_pkg::IDX_BLUE_GAIN_LOW) |=>
        blue_o.gain == {$past(blue_o.gain[8:1]), $past(wdat[0])})
        else $error("blue low gain bit wrong");
    red_high_a: assert property (wr_s(gochr_pkg::IDX_RED_GAIN_HIGH) |=>
        red_o.gain[8:1] == $past(wdat) && red_o.gain[0] == $past(red_o.gain[0])
        && green_o.gain[8:1] == $past(green_o.gain[8:1]))
        else $error("red high gain write not stored");
    green_high_a: assert property (wr_s(gochr_pkg::IDX_GREEN_GAIN_HIGH) |=>
        green_o.gain[8:1] == $past(wdat) && green_o.gain[0] == $past(green_o.gain[0])
        && blue_o.gain[8:1] == $past(blue_o.gain[8:1]))
        else $error("green high gain write not stored");
    blue_high_a: assert property (wr_s(gochr_pkg::IDX_BLUE_GAIN_HIGH) |=>
        blue_o.gain[8:1] == $past(wdat) && blue_o.gain[0] == $past(blue_o.gain[0])
        && red_o.gain[8:1] == $past(red_o.gain[8:1]))
        else $error("blue high gain write not stored");
    off_reset_a: assert property (disable iff (1'b0) rst_i |=>
        red_o.offset == gochr_pkg::RST_OFFSET && green_o.offset == gochr_pkg::RST_OFFSET
        && blue_o.offset == gochr_pkg::RST_OFFSET && green_o.gain[0] == gochr_pkg::RST_GAIN_LOW
        && blue_o.gain[0] == gochr_pkg::RST_GAIN_LOW)
        else $error("offset or low gain reset value wrong");
    hold_a: assert property (!ce_i |=>
        red_o == $past(red_o) && green_o == $past(green_o) && blue_o == $past(blue_o)
        && amp_enable_o == $past(amp_enable_o))
        else $error("state moved while clock enable low");

    // ****************************************************************
    // Mode decode checks
    // ****************************************************************
    colour_a: assert property (ce_i && !mode_ff.single_channel_setting
        && !mode_ff.two_channel_setting |=> amp_enable_o == gochr_pkg::AMP_ALL
        && op_mode_o == gochr_pkg::MODE_COLOUR && !mode_invalid_o)
        else $error("colour mode decode wrong");
    single_channel_setting_red_a: assert property (ce_i && mode_ff.single_channel_setting
        && !mode_ff.two_channel_setting && mode_ff.channel_select == gochr_pkg::SEL_RED
        |=> amp_enable_o == 3'h1 && op_mode_o == gochr_pkg::MODE_SINGLE_RED)
        else $error("single red mode decode wrong");
    single_channel_setting_blue_a: assert property (ce_i && mode_ff.single_channel_setting
        && !mode_ff.two_channel_setting && mode_ff.channel_select == gochr_pkg::SEL_BLUE
        |=> amp_enable_o == 3'h4 && op_mode_o == gochr_pkg::MODE_SINGLE_BLUE)
        else $error("single blue mode decode wrong");
    invalid_a: assert property (ce_i && mode_ff.single_channel_setting
        && (mode_ff.two_channel_setting || mode_ff.channel_select == 2'h3)
        |=> amp_enable_o == gochr_pkg::AMP_NONE && mode_invalid_o)
        else $error("invalid mode left an amplifier on");

endmodule

// ===== gochr_regs_test.sv
/*
 * Self-checking bench for the gain and offset register bank.
 * Assumes the design answers a classic Wishbone cycle with a one-cycle ack.
 */
`timescale 1ns/1ps

module gochr_regs_test;
    // ****************************************************************
    // Signals and model state
    // ****************************************************************
    logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1;
    logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'hF;
    logic [31:0] dat_i = 32'h0, dat_o, rd;
    logic ack_o, mode_invalid_o;
    logic [2:0] amp_enable_o;
    gochr_pkg::gochr_chan_type red_o, green_o, blue_o;
    gochr_pkg::gochr_mode_type op_mode_o;
    logic [31:0] seed = 32'h04B1F99C;
    int n_errors = 0, num_checks = 0;
    int off[3], glo[3], ghi[3], mode;

    gochr_regs u_gochr_regs (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .red_o(red_o), .green_o(green_o), .blue_o(blue_o),
        .amp_enable_o(amp_enable_o), .op_mode_o(op_mode_o), .mode_invalid_o(mode_invalid_o));

    initial begin
        forever #12.5 clk_i = ~clk_i;
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Mode table: {op_mode, invalid, amp enables}
    function automatic logic [6:0] mode_exp(int m);
        logic [1:0] s;
        s = m[1:0];
        if (m[3] && !m[2] && s != 2'h3)
            return {3'(gochr_pkg::MODE_SINGLE_RED + s), 1'b0, 3'(1 << s)};
        if (m[3])
            return {3'(gochr_pkg::MODE_INVALID), 1'b1, 3'h0};
        if (m[2])
            return {3'(gochr_pkg::MODE_TWO_CHANNEL), 1'b0, 3'h3};
        return {3'(gochr_pkg::MODE_COLOUR), 1'b0, 3'h7};
    endfunction

    function automatic logic [31:0] exp_rd(logic [5:0] idx);
        logic [6:0] me;
        me = mode_exp(mode);
        case (idx)
            6'h20, 6'h21, 6'h22: return 32'(off[idx-6'h20]);
            6'h24, 6'h25, 6'h26: return 32'(glo[idx-6'h24]);
            6'h28, 6'h29, 6'h2A: return 32'(ghi[idx-6'h28]);
            6'h2C: return 32'(mode);
            6'h2D: return {28'h0, me[3:0]};
            default: return 32'h0;
        endcase
    endfunction

    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic do_reset();
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            off[i] = 0;
            glo[i] = 0;
            ghi[i] = 8'h0D;
        end
        mode = 0;
    endtask

    // Classic cycle; ce_i is held low for the first stall cycles
    task automatic wb(logic w, logic [5:0] idx, logic [7:0] d, logic s0, int stall,
                      output logic [31:0] q);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= {idx, 2'(rnd())};
        dat_i <= {24'(rnd()), d};
        sel_i <= {3'h7, s0};
        ce_i <= (stall == 0);
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
            if (n == stall)
                ce_i <= 1'b1;
            if (n <= stall && ack_o !== 1'b0)
                chk("ack while stalled", 32'h0, 32'(ack_o));
        end while (ack_o !== 1'b1);
        q = dat_o;
        chk("ack cycles", 32'(stall + 2), 32'(n));
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (w && s0) begin
            case (idx)
                6'h20, 6'h21, 6'h22: off[idx-6'h20] = d;
                6'h23: off = '{d, d, d};
                6'h24, 6'h25, 6'h26: glo[idx-6'h24] = d[0];
                6'h27: glo = '{d[0], d[0], d[0]};
                6'h28, 6'h29, 6'h2A: ghi[idx-6'h28] = d;
                6'h2B: ghi = '{d, d, d};
                6'h2C: mode = d[3:0];
                default: ;
            endcase
        end
    endtask

    task automatic chk_outs();
        logic [6:0] me;
        me = mode_exp(mode);
        repeat (3) @(posedge clk_i);
        chk("red chan", 32'({ghi[0][7:0], glo[0][0], off[0][7:0]}), 32'(red_o));
        chk("green chan", 32'({ghi[1][7:0], glo[1][0], off[1][7:0]}), 32'(green_o));
        chk("blue chan", 32'({ghi[2][7:0], glo[2][0], off[2][7:0]}), 32'(blue_o));
        chk("op mode", 32'(me[6:4]), 32'(op_mode_o));
        chk("amp enable", 32'(me[2:0]), 32'(amp_enable_o));
        chk("mode invalid", 32'(me[3]), 32'(mode_invalid_o));
    endtask

    task automatic chk_all();
        logic [5:0] idx;
        chk_outs();
        for (int i = 6'h20; i <= 6'h2E; i++) begin
            idx = (i == 6'h2E) ? 6'h3F : 6'(i);
            wb(1'b0, idx, 8'h00, 1'b1, 0, rd);
            chk("read back", exp_rd(idx), rd);
        end
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        do_reset();
        chk_all();
        for (int i = 0; i < 60; i++) begin
            wb(1'b1, 6'(6'h20 + rnd() % 13), 8'(rnd()), (rnd() % 6) != 0,
               (i % 10 == 3) ? 3 : 0, rd);
            chk("write data out", 32'h0, rd);
            if (i % 15 == 14)
                chk_all();
            else
                chk_outs();
        end
        for (int m = 0; m < 16; m++) begin
            wb(1'b1, 6'h2C, 8'(m), 1'b1, 0, rd);
            chk_outs();
            wb(1'b0, 6'h2D, 8'h00, 1'b1, 0, rd);
            chk("mode status", exp_rd(6'h2D), rd);
        end
        wb(1'b1, 6'h30, 8'hA5, 1'b1, 0, rd);
        chk_all();
        do_reset();
        chk_all();
        give_verdict();
    end

    initial begin
        #(25 * 30000);
        n_errors++;
        give_verdict();
    end
endmodule
